// ==== core/csrb_int_pulse.sv ====
`timescale 1ns/1ps
module csrb_int_pulse
   import csrb_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic trig,
   output logic int_n
);

   logic [INT_CNT_W-1:0] cnt_ff;
   logic [INT_CNT_W-1:0] nxt_cnt;

   // A new event restarts the pulse rather than stacking a second one
   assign nxt_cnt = trig ? INT_CNT_W'(INT_PULSE_CYC) :
                    (cnt_ff != '0) ? cnt_ff - INT_CNT_W'(1) : cnt_ff;

   // Pulse counter
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

   // Active low while counting
   assign int_n = (cnt_ff == '0);

endmodule

// ==== core/csrb_pkg.sv ====
package csrb_pkg;

   // Register offsets on the serial bus
   localparam logic [7:0] ADDR_STATUS0 = 8'h08;
   localparam logic [7:0] ADDR_FAULT = 8'h09;
   localparam logic [7:0] ADDR_STATUS2 = 8'h0A;
   localparam logic [7:0] ADDR_PART = 8'h0B;

   // Field positions of the writable bits
   localparam int REG_RST_BIT = 7;
   localparam int VOLT_MASK_BIT = 1;
   localparam int CURR_MASK_BIT = 0;

   // Values after reset
   localparam logic [1:0] MASK_RST_VAL = 2'h0;
   localparam logic WDOG_RST_VAL = 1'b1;
   localparam logic [2:0] PART_RSVD_VAL = 3'h4;
   localparam logic [7:0] UNMAPPED_VAL = 8'h00;

   // Input source type codes
   localparam logic [2:0] SRC_NONE = 3'h0;
   localparam logic [2:0] SRC_HOST_PORT = 3'h1;
   localparam logic [2:0] SRC_ADAPTER = 3'h3;
   localparam logic [2:0] SRC_BOOST = 3'h7;

   // Charge phase codes
   localparam logic [1:0] PHASE_IDLE = 2'h0;
   localparam logic [1:0] PHASE_PRE = 2'h1;
   localparam logic [1:0] PHASE_FAST = 2'h2;
   localparam logic [1:0] PHASE_DONE = 2'h3;

   // Charge fault codes; input fault and thermal shutdown share one code
   localparam logic [1:0] CFLT_NORMAL = 2'h0;
   localparam logic [1:0] CFLT_INPUT_THERMAL = 2'h2;
   localparam logic [1:0] CFLT_TIMER = 2'h3;

   // Thermistor state codes
   localparam logic [2:0] NTC_NORMAL = 3'h0;
   localparam logic [2:0] NTC_WARM = 3'h2;
   localparam logic [2:0] NTC_COOL = 3'h3;
   localparam logic [2:0] NTC_COLD = 3'h5;
   localparam logic [2:0] NTC_HOT = 3'h6;

   // Host interrupt pulse width
   localparam int CLK_PERIOD_NS = 100;
   localparam int INT_PULSE_NS = 1000;
   localparam int INT_PULSE_CYC = (INT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int INT_CNT_W = 4;

   // Serial target states
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_RX = 5'h02,
      ST_ACK = 5'h04,
      ST_TX = 5'h08,
      ST_TACK = 5'h10
   } csrb_i2c_st_t;

   // Raw conditions from the analog charge control
   typedef struct packed {
      logic adapter_present;
      logic source_select_high;
      logic boost_mode;
      logic precharge;
      logic fast_charge;
      logic charge_done;
      logic boost_overload;
      logic boost_low_battery;
      logic input_fault;
      logic thermal_shutdown;
      logic safety_timer_expired;
      logic ts_warm;
      logic ts_cool;
      logic ts_cold;
      logic ts_hot;
   } csrb_cond_t;

   // Encoded status fields as they appear in the registers
   typedef struct packed {
      logic [2:0] input_source_type;
      logic [1:0] charge_phase;
      logic boost_fault;
      logic [1:0] charge_fault_code;
      logic [2:0] thermistor_state_code;
   } csrb_stat_t;

endpackage

// ==== core/csrb_status_bank.sv ====
`timescale 1ns/1ps
// Operation
// - Source type code: 000 none, 001 host port, 011 adapter, 111 boost.
// - Applied current limit is shown in its own setting register, not here.
// - Charge phase: 00 idle, 01 precharge, 10 fast, 11 terminated.
// - Power good bit follows input power; thermal bit follows thermal regulation.
// - Minimum system flag is set while battery is below minimum system voltage.
// - Watchdog flag sets on expiry, reads 0 in host mode, 1 after power-on.
// - Boost fault flags any invalid boost condition, overload or low battery.
// - Charge fault: 00 normal, 10 input or thermal, 11 safety timer expired.
// - Battery fault flag follows battery overvoltage.
// - Buck thermistor code: 000 normal, 010 warm, 011 cool, 101 cold, 110 hot.
// - Boost thermistor code limited to 000 normal, 101 cold, 110 hot.
// - Input good flag follows poor source detection pass.
// - Sense fault flag set while remote sense pin is open or shorted.
// - Top-off flag set while the top-off timer counts.
// - Voltage regulation status; interrupt pulse on entry unless mask bit 1 set.
// - Current regulation status; interrupt pulse on entry unless mask bit 0 set.
// - Writing register reset returns registers to defaults and restarts safety timer.
// - Register reset bit clears itself once the reset is done.
module csrb_status_bank
   import csrb_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h2B, // Arbitrary value
   parameter logic [3:0] PART_CODE = 4'h3 // Arbitrary value
)
(
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic SCL,
   input wire logic SDA_I,
   output logic SDA_O,
   output logic SDA_OE,
   input wire logic ADAPTER_PRESENT,
   input wire logic SOURCE_SELECT_HIGH,
   input wire logic BOOST_MODE,
   input wire logic PRECHARGE,
   input wire logic FAST_CHARGE,
   input wire logic CHARGE_DONE,
   input wire logic POWER_GOOD,
   input wire logic THERMAL_REG,
   input wire logic VBAT_BELOW_SYSMIN,
   input wire logic WATCHDOG_EXPIRE,
   input wire logic HOST_MODE_ENTER,
   input wire logic BOOST_OVERLOAD,
   input wire logic BOOST_LOW_BATTERY,
   input wire logic INPUT_FAULT,
   input wire logic THERMAL_SHUTDOWN,
   input wire logic SAFETY_TIMER_EXPIRED,
   input wire logic BATTERY_OV,
   input wire logic TS_WARM,
   input wire logic TS_COOL,
   input wire logic TS_COLD,
   input wire logic TS_HOT,
   input wire logic INPUT_GOOD,
   input wire logic INPUT_VOLTAGE_REG,
   input wire logic INPUT_CURRENT_REG,
   input wire logic REMOTE_SENSE_FAULT,
   input wire logic TOPOFF_RUNNING,
   input wire logic INPUT_OV,
   output logic INT_N,
   output logic REGISTER_RESET,
   output logic SAFETY_TIMER_RESTART
);

   csrb_cond_t cond;
   csrb_stat_t stat;
   csrb_i2c_st_t st_ff;
   csrb_i2c_st_t nxt_st;
   logic scl_ff, scl_d_ff, sda_ff, sda_d_ff;
   logic [3:0] cnt_ff, nxt_cnt;
   logic [7:0] shift_ff, nxt_shift;
   logic [7:0] tx_ff, nxt_tx;
   logic [7:0] ptr_ff, nxt_ptr;
   logic first_ff, nxt_first;
   logic need_ptr_ff, nxt_need_ptr;
   logic rw_ff, nxt_rw;
   logic nack_ff, nxt_nack;
   logic [1:0] mask_ff;
   logic reg_rst_ff;
   logic wdog_ff;
   logic vreg_d_ff, ireg_d_ff;
   logic scl_rise, scl_fall, bus_start, bus_stop;
   logic byte_in, addr_hit, wr_stb, rd_load;
   logic [7:0] rd_data, stat0_val, fault_val, stat2_val, part_val;
   logic wr_stat2, wr_part, int_trig;

   // Raw conditions into one carrier
   assign cond = '{adapter_present: ADAPTER_PRESENT, source_select_high: SOURCE_SELECT_HIGH,
                   boost_mode: BOOST_MODE, precharge: PRECHARGE, fast_charge: FAST_CHARGE,
                   charge_done: CHARGE_DONE, boost_overload: BOOST_OVERLOAD,
                   boost_low_battery: BOOST_LOW_BATTERY, input_fault: INPUT_FAULT,
                   thermal_shutdown: THERMAL_SHUTDOWN, safety_timer_expired: SAFETY_TIMER_EXPIRED,
                   ts_warm: TS_WARM, ts_cool: TS_COOL, ts_cold: TS_COLD, ts_hot: TS_HOT};

   csrb_status_enc u_enc (
      .cond(cond),
      .stat(stat)
   );

   // Bus line edges; pins are already synchronous to CLK
   assign scl_rise = scl_ff & ~scl_d_ff;
   assign scl_fall = ~scl_ff & scl_d_ff;
   assign bus_start = scl_ff & scl_d_ff & sda_d_ff & ~sda_ff;
   assign bus_stop = scl_ff & scl_d_ff & ~sda_d_ff & sda_ff;

   // Byte completion and its meaning
   assign byte_in = (st_ff == ST_RX) & scl_fall & (cnt_ff == 4'h8);
   assign addr_hit = (shift_ff[7:1] == DEV_ADDR);
   assign wr_stb = byte_in & ~first_ff & ~need_ptr_ff;
   assign rd_load = scl_fall & (((st_ff == ST_ACK) & rw_ff) | ((st_ff == ST_TACK) & ~nack_ff));

   // Live register images, sampled when a read byte is loaded
   assign stat0_val = {stat.input_source_type, stat.charge_phase, POWER_GOOD,
                       THERMAL_REG, VBAT_BELOW_SYSMIN};
   assign fault_val = {wdog_ff, stat.boost_fault, stat.charge_fault_code,
                       BATTERY_OV, stat.thermistor_state_code};
   assign stat2_val = {INPUT_GOOD, INPUT_VOLTAGE_REG, INPUT_CURRENT_REG,
                       REMOTE_SENSE_FAULT, TOPOFF_RUNNING, INPUT_OV, mask_ff};
   assign part_val = {reg_rst_ff, PART_CODE, PART_RSVD_VAL};

   // Read mux; unmapped offsets read as zero
   assign rd_data = (ptr_ff == ADDR_STATUS0) ? stat0_val :
                    (ptr_ff == ADDR_FAULT) ? fault_val :
                    (ptr_ff == ADDR_STATUS2) ? stat2_val :
                    (ptr_ff == ADDR_PART) ? part_val : UNMAPPED_VAL;

   // Only the mask pair and the reset bit accept writes
   assign wr_stat2 = wr_stb & (ptr_ff == ADDR_STATUS2);
   assign wr_part = wr_stb & (ptr_ff == ADDR_PART) & shift_ff[REG_RST_BIT];

   // Serial target sequencing
   always_comb begin
      nxt_st = st_ff;
      nxt_cnt = cnt_ff;
      nxt_shift = shift_ff;
      nxt_tx = tx_ff;
      nxt_ptr = ptr_ff;
      nxt_first = first_ff;
      nxt_need_ptr = need_ptr_ff;
      nxt_rw = rw_ff;
      nxt_nack = nack_ff;
      if (bus_start) begin
         nxt_st = ST_RX;
         nxt_cnt = 4'h0;
         nxt_first = 1'b1;
      end else if (bus_stop) begin
         nxt_st = ST_IDLE;
      end else begin
         unique case (st_ff)
            ST_IDLE: begin
               nxt_st = ST_IDLE;
            end
            ST_RX: begin
               if (scl_rise && cnt_ff != 4'h8) begin
                  nxt_shift = {shift_ff[6:0], sda_ff};
                  nxt_cnt = cnt_ff + 4'h1;
               end else if (byte_in) begin
                  nxt_st = ST_ACK;
                  if (first_ff) begin
                     nxt_first = 1'b0;
                     nxt_rw = shift_ff[0];
                     nxt_need_ptr = ~shift_ff[0];
                     if (!addr_hit) begin
                        nxt_st = ST_IDLE;
                     end
                  end else if (need_ptr_ff) begin
                     nxt_ptr = shift_ff;
                     nxt_need_ptr = 1'b0;
                  end else begin
                     nxt_ptr = ptr_ff + 8'h01;
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  nxt_cnt = 4'h0;
                  nxt_st = rw_ff ? ST_TX : ST_RX;
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  nxt_cnt = cnt_ff + 4'h1;
                  nxt_tx = {tx_ff[6:0], 1'b0};
                  if (cnt_ff == 4'h7) begin
                     nxt_st = ST_TACK;
                  end
               end
            end
            ST_TACK: begin
               if (scl_rise) begin
                  nxt_nack = sda_ff;
               end else if (scl_fall) begin
                  nxt_cnt = 4'h0;
                  nxt_st = nack_ff ? ST_IDLE : ST_TX;
               end
            end
         endcase
         // Read byte taken from the live image at the start of each byte
         if (rd_load) begin
            nxt_tx = rd_data;
            nxt_ptr = ptr_ff + 8'h01;
         end
      end
   end

   // Serial target state
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         st_ff <= ST_IDLE;
         cnt_ff <= 4'h0;
         shift_ff <= 8'h00;
         tx_ff <= 8'h00;
         ptr_ff <= 8'h00;
         first_ff <= 1'b1;
         need_ptr_ff <= 1'b0;
         rw_ff <= 1'b0;
         nack_ff <= 1'b1;
      end else begin
         st_ff <= nxt_st;
         cnt_ff <= nxt_cnt;
         shift_ff <= nxt_shift;
         tx_ff <= nxt_tx;
         ptr_ff <= nxt_ptr;
         first_ff <= nxt_first;
         need_ptr_ff <= nxt_need_ptr;
         rw_ff <= nxt_rw;
         nack_ff <= nxt_nack;
      end
   end

   // Line samples and edge history
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         scl_ff <= 1'b1;
         scl_d_ff <= 1'b1;
         sda_ff <= 1'b1;
         sda_d_ff <= 1'b1;
      end else begin
         scl_ff <= SCL;
         scl_d_ff <= scl_ff;
         sda_ff <= SDA_I;
         sda_d_ff <= sda_ff;
      end
   end

   // Open drain: only ever pull low, during ack or a zero data bit
   assign SDA_O = 1'b0;
   assign SDA_OE = (st_ff == ST_ACK) | ((st_ff == ST_TX) & ~tx_ff[7]);

   // Masks, register reset and watchdog flag; expiry wins over host mode entry
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         mask_ff <= MASK_RST_VAL;
         reg_rst_ff <= 1'b0;
         wdog_ff <= WDOG_RST_VAL;
      end else begin
         if (reg_rst_ff) begin
            mask_ff <= MASK_RST_VAL;
         end else if (wr_stat2) begin
            mask_ff <= shift_ff[VOLT_MASK_BIT:CURR_MASK_BIT];
         end
         reg_rst_ff <= wr_part & ~reg_rst_ff;
         if (WATCHDOG_EXPIRE) begin
            wdog_ff <= 1'b1;
         end else if (HOST_MODE_ENTER) begin
            wdog_ff <= 1'b0;
         end
      end
   end

   // One-cycle reset pulses to the rest of the charger
   assign REGISTER_RESET = reg_rst_ff;
   assign SAFETY_TIMER_RESTART = reg_rst_ff;

   // Regulation entry edges
   always_ff @(posedge CLK) begin
      if (!RESET_N) begin
         vreg_d_ff <= 1'b0;
         ireg_d_ff <= 1'b0;
      end else begin
         vreg_d_ff <= INPUT_VOLTAGE_REG;
         ireg_d_ff <= INPUT_CURRENT_REG;
      end
   end

   // A mask only blocks the pulse; the status bit still reads live
   assign int_trig = (INPUT_VOLTAGE_REG & ~vreg_d_ff & ~mask_ff[VOLT_MASK_BIT]) |
                     (INPUT_CURRENT_REG & ~ireg_d_ff & ~mask_ff[CURR_MASK_BIT]);

   csrb_int_pulse u_int (
      .clk(CLK),
      .reset_n(RESET_N),
      .trig(int_trig),
      .int_n(INT_N)
   );

   // Checks
   src_boost_a: assert property (@(posedge CLK) disable iff (!RESET_N)
      BOOST_MODE |-> stat0_val[7:5] == SRC_BOOST) else $error("boost source code wrong");
   src_host_a: assert property (@(posedge CLK) disable iff (!RESET_N)
      (ADAPTER_PRESENT && !BOOST_MODE) |-> stat0_val[7:5] ==
      (SOURCE_SELECT_HIGH ? SRC_HOST_PORT : SRC_ADAPTER)) else $error("source code wrong");
   phase_code_a: assert property (@(posedge CLK) disable iff (!RESET_N)
      (FAST_CHARGE && !CHARGE_DONE) |-> stat0_val[4:3] == PHASE_FAST)
      else $error("fast phase code wrong");
   sysmin_flag_a: assert property (@(posedge CLK) disable iff (!RESET_N)
      stat0_val[0] == VBAT_BELOW_SYSMIN) else $error("sysmin flag wrong");
   wdog_flag_a: assert property (@(posedge CLK) disable iff (!RESET_N)
      WATCHDOG_EXPIRE |=> fault_val[7]) else $error("watchdog flag not set");
   wdog_host_a: assert property (@(posedge CLK) disable iff (!RESET_N)
      (HOST_MODE_ENTER && !WATCHDOG_EXPIRE) |=> !fault_val[7])
      else $error("watchdog flag not cleared");
   boost_fault_a: assert property (@(posedge CLK) disable iff (!RESET_N)
      BOOST_LOW_BATTERY |-> fault_val[6]) else $error("boost fault missing");
   chg_fault_a: assert property (@(posedge CLK) disable iff (!RESET_N)
      (THERMAL_SHUTDOWN && !SAFETY_TIMER_EXPIRED) |-> fault_val[5:4] == CFLT_INPUT_THERMAL)
      else $error("charge fault code wrong");
   ntc_boost_a: assert property (@(posedge CLK) disable iff (!RESET_N)
      (BOOST_MODE && TS_WARM && !TS_HOT && !TS_COLD) |-> fault_val[2:0] == NTC_NORMAL)
      else $error("warm shown in boost");
   ntc_buck_a: assert property (@(posedge CLK) disable iff (!RESET_N)
      (!BOOST_MODE && TS_COOL && !TS_WARM && !TS_HOT && !TS_COLD) |->
      fault_val[2:0] == NTC_COOL) else $error("cool code wrong");
   volt_int_a: assert property (@(posedge CLK) disable iff (!RESET_N)
      $rose(INPUT_VOLTAGE_REG) && !mask_ff[VOLT_MASK_BIT] |=> !INT_N [*2])
      else $error("no pulse on voltage regulation");
   curr_mask_a: assert property (@(posedge CLK) disable iff (!RESET_N)
      (INT_N && mask_ff[CURR_MASK_BIT] && !$rose(INPUT_VOLTAGE_REG)) |=> INT_N)
      else $error("masked pulse seen");
   reg_reset_a: assert property (@(posedge CLK) disable iff (!RESET_N)
      wr_part && !reg_rst_ff |=> SAFETY_TIMER_RESTART ##1 mask_ff == MASK_RST_VAL)
      else $error("register reset incomplete");
   self_clear_a: assert property (@(posedge CLK) disable iff (!RESET_N)
      reg_rst_ff |=> !reg_rst_ff) else $error("reset bit stuck");
   ro_write_a: assert property (@(posedge CLK) disable iff (!RESET_N)
      wr_stb && ptr_ff == ADDR_FAULT |=> $stable(mask_ff) && !reg_rst_ff)
      else $error("read-only write took effect");

   // Main scenarios
   read_fault_c: cover property (@(posedge CLK) disable iff (!RESET_N)
      rd_load && ptr_ff == ADDR_FAULT);
   mask_write_c: cover property (@(posedge CLK) disable iff (!RESET_N) wr_stat2);
   reg_reset_c: cover property (@(posedge CLK) disable iff (!RESET_N) reg_rst_ff);
   int_pulse_c: cover property (@(posedge CLK) disable iff (!RESET_N) $fell(INT_N));

endmodule

// ==== core/csrb_status_enc.sv ====
`timescale 1ns/1ps
module csrb_status_enc
   import csrb_pkg::*;
(
   input wire csrb_cond_t cond,
   output csrb_stat_t stat
);

   logic [2:0] src;
   logic [1:0] phase;
   logic [1:0] cflt;
   logic [2:0] ntc_buck;
   logic [2:0] ntc_boost;

   // Source code only names the source; the applied limit lives elsewhere
   assign src = cond.boost_mode ? SRC_BOOST :
                !cond.adapter_present ? SRC_NONE :
                cond.source_select_high ? SRC_HOST_PORT : SRC_ADAPTER;

   // Later phases win if the analog side flags two at once
   assign phase = cond.charge_done ? PHASE_DONE :
                  cond.fast_charge ? PHASE_FAST :
                  cond.precharge ? PHASE_PRE : PHASE_IDLE;

   // Timer expiry outranks the shared input/thermal code
   assign cflt = cond.safety_timer_expired ? CFLT_TIMER :
                 (cond.input_fault || cond.thermal_shutdown) ? CFLT_INPUT_THERMAL : CFLT_NORMAL;

   // Buck mode reports all five zones, hot and cold first
   assign ntc_buck = cond.ts_hot ? NTC_HOT : cond.ts_cold ? NTC_COLD :
                     cond.ts_warm ? NTC_WARM : cond.ts_cool ? NTC_COOL : NTC_NORMAL;
   // Boost mode knows only hot and cold
   assign ntc_boost = cond.ts_hot ? NTC_HOT : cond.ts_cold ? NTC_COLD : NTC_NORMAL;

   // Pack the fields
   assign stat.input_source_type = src;
   assign stat.charge_phase = phase;
   assign stat.boost_fault = cond.boost_overload | cond.boost_low_battery;
   assign stat.charge_fault_code = cflt;
   assign stat.thermistor_state_code = cond.boost_mode ? ntc_boost : ntc_buck;

endmodule

// ==== verification/csrb_host_model.sv ====
`timescale 1ns/1ps
// Serial bus controller in the host's place; released SDA reads high through the pull-up
module csrb_host_model
   import csrb_pkg::*;
#(
   parameter logic [6:0] DEV = 7'h2B
)
(
   input wire logic clk,
   input wire logic sda_in,
   output logic scl,
   output logic sda_pull
);
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   // Six-clock phases keep SCL well above the four-clock minimum each way
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Data moves 2 clocks after SCL falls, so it never changes while SCL is high
   task automatic put_bit(input logic b, output logic got);
      tick(2);
      sda_pull <= ~b;
      tick(4);
      scl <= 1'b1;
      tick(6);
      got = sda_in;
      scl <= 1'b0;
   endtask
   // Also serves as repeated start, since it releases SDA before raising SCL
   task automatic start;
      tick(2);
      sda_pull <= 1'b0;
      tick(4);
      scl <= 1'b1;
      tick(6);
      sda_pull <= 1'b1;
      tick(6);
      scl <= 1'b0;
   endtask
   task automatic stop;
      tick(2);
      sda_pull <= 1'b1;
      tick(4);
      scl <= 1'b1;
      tick(6);
      sda_pull <= 1'b0;
      tick(6);
   endtask
   // One byte MSB first, then the ninth bit with SDA released
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
      logic n;
      for (int i = 7; i >= 0; i--) put_bit(tx[i], rx[i]);
      put_bit(1'b1, n);
      ack = ~n;
   endtask
   // Reports whether the target acknowledged all three bytes
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
      logic [7:0] r;
      logic k;
      start();
      xfer({DEV, 1'b0}, r, k);
      ok = k;
      xfer(a, r, k);
      ok &= k;
      xfer(d, r, k);
      ok &= k;
      stop();
   endtask
   // Single-byte read; the released ninth bit is the closing refusal
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      logic [7:0] r;
      logic k;
      start();
      xfer({DEV, 1'b0}, r, k);
      xfer(a, r, k);
      start();
      xfer({DEV, 1'b1}, r, k);
      xfer(8'hFF, d, k);
      stop();
   endtask
endmodule

// ==== verification/test_charger_status_register_bank.sv ====
`timescale 1ns/1ps
module test_charger_status_register_bank;
   import csrb_pkg::*;
   localparam logic [3:0] PC = 4'h9; // Arbitrary value
   logic clk, rst_n, scl, pull, wexp, hent, wd;
   logic [24:0] c;
   logic [1:0] msk;
   wire sda_oe, sda_o, int_n, rr, st;
   wire sda = ~(pull | (sda_oe & ~sda_o));
   int err_count = 0, total_checks = 0, rr_n = 0, st_n = 0;
   csrb_status_bank #(.DEV_ADDR(7'h2B), .PART_CODE(PC)) csrb_status_bank_inst(.CLK(clk),
      .RESET_N(rst_n), .SCL(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe),
      .ADAPTER_PRESENT(c[0]), .SOURCE_SELECT_HIGH(c[1]), .BOOST_MODE(c[2]), .PRECHARGE(c[3]),
      .FAST_CHARGE(c[4]), .CHARGE_DONE(c[5]), .POWER_GOOD(c[6]), .THERMAL_REG(c[7]),
      .VBAT_BELOW_SYSMIN(c[8]), .WATCHDOG_EXPIRE(wexp), .HOST_MODE_ENTER(hent),
      .BOOST_OVERLOAD(c[9]), .BOOST_LOW_BATTERY(c[10]), .INPUT_FAULT(c[11]),
      .THERMAL_SHUTDOWN(c[12]), .SAFETY_TIMER_EXPIRED(c[13]), .BATTERY_OV(c[14]),
      .TS_WARM(c[15]), .TS_COOL(c[16]), .TS_COLD(c[17]), .TS_HOT(c[18]), .INPUT_GOOD(c[19]),
      .INPUT_VOLTAGE_REG(c[20]), .INPUT_CURRENT_REG(c[21]), .REMOTE_SENSE_FAULT(c[22]),
      .TOPOFF_RUNNING(c[23]), .INPUT_OV(c[24]), .INT_N(int_n), .REGISTER_RESET(rr),
      .SAFETY_TIMER_RESTART(st));
   csrb_host_model #(.DEV(7'h2B)) csrb_host_model_inst(.clk(clk), .sda_in(sda), .scl(scl),
      .sda_pull(pull));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Pulses are counted here because they come and go in the middle of a write
   always @(posedge clk) begin
      if (rr === 1'b1) rr_n++;
      if (st === 1'b1) st_n++;
   end
   // Reference image of each register from the live inputs and the tracked state
   function automatic logic [7:0] exp_reg(input logic [7:0] a);
      logic [2:0] src, ntc;
      logic [1:0] ph, cf;
      src = c[2] ? 3'h7 : !c[0] ? 3'h0 : c[1] ? 3'h1 : 3'h3;
      ph = c[5] ? 2'h3 : c[4] ? 2'h2 : c[3] ? 2'h1 : 2'h0;
      cf = c[13] ? 2'h3 : (c[11] | c[12]) ? 2'h2 : 2'h0;
      ntc = c[18] ? 3'h6 : c[17] ? 3'h5 : c[2] ? 3'h0 : c[15] ? 3'h2 : c[16] ? 3'h3 : 3'h0;
      case (a)
         8'h08: return {src, ph, c[6], c[7], c[8]};
         8'h09: return {wd, c[9] | c[10], cf, c[14], ntc};
         8'h0A: return {c[19], c[20], c[21], c[22], c[23], c[24], msk};
         8'h0B: return {1'b0, PC, PART_RSVD_VAL};
         default: return UNMAPPED_VAL;
      endcase
   endfunction
   task automatic chk(input logic [7:0] s, input logic [7:0] e, input string m);
      total_checks++;
      if (s !== e) begin
         err_count++;
         $display("wrong value at %0t: %s got %h expected %h", $time, m, s, e);
      end
   endtask
   task automatic rd(input logic [7:0] a, input string m);
      logic [7:0] d;
      csrb_host_model_inst.read_reg(a, d);
      chk(d, exp_reg(a), m);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic ok;
      csrb_host_model_inst.write_reg(a, d, ok);
      chk({7'h00, ok}, 8'h01, "write acknowledged");
   endtask
   // One-cycle pulse on the watchdog expiry or the host mode entry input
   task automatic pulse(input bit expire);
      @(posedge clk);
      if (expire) wexp <= 1'b1;
      else hent <= 1'b1;
      @(posedge clk);
      wexp <= 1'b0;
      hent <= 1'b0;
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // The plan needs about 25,000 clocks; twice that still stays inside the run budget
   initial begin
      #5_000_000;
      err_count++;
      close_out();
   end
   initial begin
      int lo, lo_st;
      c = '0;
      wexp = 1'b0;
      hent = 1'b0;
      rst_n = 1'b0;
      msk = 2'h0;
      wd = 1'b1;
      void'($urandom(32'h7761_00f7));
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      rd(8'h09, "watchdog at power-on");
      rd(8'h0A, "masks at reset");
      rd(8'h0B, "part info");
      $display("test reset values done");
      // Random live conditions; status must follow the inputs at each read
      for (int i = 0; i < 10; i++) begin
         @(posedge clk);
         c <= 25'($urandom);
         rd(8'h08, "status 0");
         rd(8'h09, "fault status");
         rd(8'h0A, "status 2");
      end
      $display("test live status done");
      pulse(1'b0);
      wd = 1'b0;
      rd(8'h09, "watchdog host mode");
      pulse(1'b1);
      wd = 1'b1;
      rd(8'h09, "watchdog expired");
      $display("test watchdog done");
      wr(8'h08, 8'hFF);
      wr(8'h09, 8'h00);
      wr(8'h0B, 8'h7F);
      rd(8'h08, "write to status 0");
      rd(8'h09, "write to faults");
      rd(8'h0B, "write to part info");
      rd(8'h10, "unmapped offset");
      $display("test read-only writes done");
      // Every mask setting against both regulation events
      for (int k = 0; k < 4; k++) begin
         msk = k[1:0];
         wr(8'h0A, {6'h3F, msk});
         rd(8'h0A, "mask write");
         @(posedge clk);
         c[21:20] <= 2'b00;
         repeat (12) @(posedge clk);
         for (int s = 0; s < 2; s++) begin
            lo = 0;
            c[20 + s] <= 1'b1;
            repeat (14) begin
               @(posedge clk);
               #1 if (int_n === 1'b0) lo++;
            end
            chk(8'(lo), msk[1 - s] ? 8'h00 : 8'(INT_PULSE_CYC), "interrupt width");
         end
      end
      $display("test interrupt masks done");
      lo = rr_n;
      lo_st = st_n;
      wr(8'h0B, 8'h80);
      msk = 2'h0;
      chk(8'(rr_n - lo), 8'h01, "register reset pulse");
      chk(8'(st_n - lo_st), 8'h01, "safety timer restart");
      rd(8'h0A, "masks after register reset");
      rd(8'h0B, "reset bit self-cleared");
      $display("test register reset done");
      close_out();
   end
endmodule
